// ==== core/ris_sequencer.sv ====
// ROI index sequencer: trigger and command driven index stepping
// Operation
// - Mode selector: normal, trigger, command, multi
// - Index holds for its frame count
// - Successor is index 0-9 or off
// - Repeat count used only with off entry
// - First trigger after start runs index 0
// - Off entry done decrements repeat copy
// - Nonzero repeat restarts table at index 0
// - Zero repeat stops, further triggers ignored
// - Selection command accepted only in command mode
// - Selected index applies at next trigger
// - Command mode ignores frames and successor
// - No command yet: trigger runs index 0
// - No new command: repeat previous index
`default_nettype none
module ris_sequencer #(
    parameter int unsigned NUM_INDEX = ris_pkg::NUM_INDEX
) (
    input  wire logic                      ref_clk_in,
    input  wire logic                      rst_n_in,
    input  wire logic [ris_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [ris_pkg::DATA_W-1:0] wdata_in,
    input  wire logic                      wr_in,
    input  wire logic                      rd_in,
    output logic      [ris_pkg::DATA_W-1:0] rdata_out,
    input  wire logic                      trigger_in,
    output logic                           frame_start_out,
    output logic      [3:0]                index_out,
    output logic      [1:0]                mode_out,
    output logic                           active_out,
    output logic                           irq_out
);
    // ==========================================================
    // Trigger synchroniser
    logic trig_rise;

    ris_sync u_sync (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .async_in   (trigger_in),
        .rise_out   (trig_rise)
    );

    // ==========================================================
    // Register state
    localparam int unsigned IRQ_W_L = ris_pkg::IRQ_W;

    ris_pkg::ris_mode_e mode;
    ris_pkg::ris_mode_e next_mode;
    logic [7:0]  repeat_cfg;
    logic [7:0]  next_repeat_cfg;
    logic [7:0]  tbl_frames [NUM_INDEX];
    logic [3:0]  tbl_succ   [NUM_INDEX];
    logic        tbl_off    [NUM_INDEX];
    logic [IRQ_W_L-1:0] irq_st;
    logic [IRQ_W_L-1:0] next_irq_st;
    logic [IRQ_W_L-1:0] irq_msk;
    logic [IRQ_W_L-1:0] next_irq_msk;
    logic [ris_pkg::DATA_W-1:0] next_rdata;

    // Sequencer state
    logic        active;
    logic        next_active;
    logic [3:0]  cur_idx;
    logic [3:0]  next_cur_idx;
    logic [7:0]  frm_cnt;
    logic [7:0]  next_frm_cnt;
    logic [7:0]  rep_cnt;
    logic [7:0]  next_rep_cnt;
    // Selection command seen since the last start
    logic        started;
    logic        next_started;
    logic [3:0]  cmd_idx;
    logic [3:0]  next_cmd_idx;
    logic        frame_start;
    logic        next_frame_start;
    logic [3:0]  out_idx;
    logic [3:0]  next_out_idx;

    // ==========================================================
    // Command decode
    logic        wr_ctrl;
    logic        start_cmd;
    logic        stop_cmd;
    logic        sel_cmd;
    logic        any_off;
    logic [IRQ_W_L-1:0] ev;

    assign wr_ctrl   = wr_in && (addr_in == ris_pkg::OFS_CTRL);
    assign start_cmd = wr_ctrl && wdata_in[ris_pkg::CTRL_START_BIT];
    assign stop_cmd  = wr_ctrl && wdata_in[ris_pkg::CTRL_STOP_BIT];
    assign sel_cmd   = wr_in && (addr_in == ris_pkg::OFS_CMD)
                       && (mode == ris_pkg::RIS_MODE_CMD_SEQ)
                       && (wdata_in[3:0] < 4'(NUM_INDEX));

    always_comb begin
        any_off = 1'b0;
        for (int i = 0; i < NUM_INDEX; i++) begin
            any_off = any_off | tbl_off[i];
        end
    end

    // ==========================================================
    // Index table, one register per entry
    generate
        for (genvar g = 0; g < NUM_INDEX; g++) begin : g_tbl
            localparam logic [7:0] OFS = 8'(ris_pkg::OFS_TABLE + 4 * g);
            logic [7:0] next_f;
            logic [3:0] next_s;
            logic       next_o;
            always_comb begin
                next_f = tbl_frames[g];
                next_s = tbl_succ[g];
                next_o = tbl_off[g];
                if (wr_in && addr_in == OFS) begin
                    if (wdata_in[ris_pkg::ENT_FRM_LSB +: 8] != 8'h00) begin
                        next_f = wdata_in[ris_pkg::ENT_FRM_LSB +: 8];
                    end
                    if (wdata_in[ris_pkg::ENT_SUCC_LSB +: 4] < 4'(NUM_INDEX)) begin
                        next_s = wdata_in[ris_pkg::ENT_SUCC_LSB +: 4];
                    end
                    next_o = wdata_in[ris_pkg::ENT_OFF_BIT];
                end
            end
            always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    tbl_frames[g] <= ris_pkg::RST_FRAMES;
                    tbl_succ[g]   <= ris_pkg::RST_INDEX;
                    tbl_off[g]    <= 1'b0;
                end else begin
                    tbl_frames[g] <= next_f;
                    tbl_succ[g]   <= next_s;
                    tbl_off[g]    <= next_o;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Sequencer next state
    always_comb begin
        next_active      = active;
        next_cur_idx     = cur_idx;
        next_frm_cnt     = frm_cnt;
        next_rep_cnt     = rep_cnt;
        next_started     = started;
        next_cmd_idx     = cmd_idx;
        next_frame_start = 1'b0;
        next_out_idx     = out_idx;
        ev               = '0;
        if (sel_cmd) begin
            next_cmd_idx = wdata_in[3:0];
            next_started = 1'b1;
        end
        if (start_cmd) begin
            next_active  = 1'b1;
            next_started = 1'b0;
            next_cur_idx = ris_pkg::RST_INDEX;
            next_frm_cnt = tbl_frames[0];
            next_rep_cnt = repeat_cfg;
            next_cmd_idx = ris_pkg::RST_INDEX;
        end else if (stop_cmd) begin
            next_active = 1'b0;
        end else if (trig_rise && !active) begin
            ev[ris_pkg::IRQ_IGN] = 1'b1;
        end else if (trig_rise) begin
            next_frame_start = 1'b1;
            ev[ris_pkg::IRQ_FRAME] = 1'b1;
            unique case (mode)
                ris_pkg::RIS_MODE_TRIG_SEQ: begin
                    next_out_idx = cur_idx;
                    if (frm_cnt > 8'h01) begin
                        next_frm_cnt = frm_cnt - 8'h01;
                    end else if (tbl_off[cur_idx] && any_off) begin
                        // Pass done: back to index 0, stop on last pass
                        ev[ris_pkg::IRQ_PASS] = 1'b1;
                        next_rep_cnt = rep_cnt - 8'h01;
                        next_cur_idx = ris_pkg::RST_INDEX;
                        next_frm_cnt = tbl_frames[0];
                        if (rep_cnt == 8'h01) begin
                            next_active = 1'b0;
                            ev[ris_pkg::IRQ_STOP] = 1'b1;
                        end
                    end else begin
                        next_cur_idx = tbl_succ[cur_idx];
                        next_frm_cnt = tbl_frames[tbl_succ[cur_idx]];
                    end
                end
                ris_pkg::RIS_MODE_CMD_SEQ: begin
                    // A write in this cycle counts for the next trigger
                    if (started) begin
                        next_out_idx = cmd_idx;
                    end else begin
                        next_out_idx = ris_pkg::RST_INDEX;
                    end
                    next_cur_idx = cmd_idx;
                end
                default: begin
                    next_out_idx = ris_pkg::RST_INDEX;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            active      <= 1'b0;
            cur_idx     <= ris_pkg::RST_INDEX;
            frm_cnt     <= ris_pkg::RST_FRAMES;
            rep_cnt     <= ris_pkg::RST_REPEAT;
            started     <= 1'b0;
            cmd_idx     <= ris_pkg::RST_INDEX;
            frame_start <= 1'b0;
            out_idx     <= ris_pkg::RST_INDEX;
        end else begin
            active      <= next_active;
            cur_idx     <= next_cur_idx;
            frm_cnt     <= next_frm_cnt;
            rep_cnt     <= next_rep_cnt;
            started     <= next_started;
            cmd_idx     <= next_cmd_idx;
            frame_start <= next_frame_start;
            out_idx     <= next_out_idx;
        end
    end

    // ==========================================================
    // Register bus
    always_comb begin
        next_mode       = mode;
        next_repeat_cfg = repeat_cfg;
        next_irq_msk    = irq_msk;
        next_irq_st     = irq_st;
        next_rdata      = ris_pkg::RD_ZERO;
        if (wr_ctrl) begin
            next_mode = ris_pkg::ris_mode_e'(wdata_in[ris_pkg::CTRL_MODE_LSB +: 2]);
        end
        if (wr_in && addr_in == ris_pkg::OFS_REPEAT && wdata_in[7:0] != 8'h00) begin
            next_repeat_cfg = wdata_in[7:0];
        end
        if (wr_in && addr_in == ris_pkg::OFS_IRQ_MSK) begin
            next_irq_msk = wdata_in[IRQ_W_L-1:0];
        end
        if (wr_in && addr_in == ris_pkg::OFS_IRQ_ST) begin
            next_irq_st = irq_st & ~wdata_in[IRQ_W_L-1:0];
        end
        next_irq_st = next_irq_st | ev;
        if (rd_in) begin
            if (addr_in == ris_pkg::OFS_CTRL) begin
                next_rdata[ris_pkg::CTRL_MODE_LSB +: 2] = mode;
            end else if (addr_in == ris_pkg::OFS_REPEAT) begin
                next_rdata[7:0] = repeat_cfg;
            end else if (addr_in == ris_pkg::OFS_CMD) begin
                next_rdata[3:0] = cmd_idx;
            end else if (addr_in == ris_pkg::OFS_STATUS) begin
                next_rdata[ris_pkg::ST_IDX_LSB +: 4] = cur_idx;
                next_rdata[ris_pkg::ST_ACT_BIT]      = active;
                next_rdata[ris_pkg::ST_FRM_LSB +: 8] = frm_cnt;
                next_rdata[ris_pkg::ST_REP_LSB +: 8] = rep_cnt;
            end else if (addr_in == ris_pkg::OFS_IRQ_ST) begin
                next_rdata[IRQ_W_L-1:0] = irq_st;
            end else if (addr_in == ris_pkg::OFS_IRQ_MSK) begin
                next_rdata[IRQ_W_L-1:0] = irq_msk;
            end else begin
                for (int i = 0; i < NUM_INDEX; i++) begin
                    if (addr_in == 8'(ris_pkg::OFS_TABLE + 4 * i)) begin
                        next_rdata[ris_pkg::ENT_FRM_LSB +: 8]  = tbl_frames[i];
                        next_rdata[ris_pkg::ENT_SUCC_LSB +: 4] = tbl_succ[i];
                        next_rdata[ris_pkg::ENT_OFF_BIT]       = tbl_off[i];
                    end
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode       <= ris_pkg::RIS_MODE_NORMAL;
            repeat_cfg <= ris_pkg::RST_REPEAT;
            irq_msk    <= '0;
            irq_st     <= '0;
            rdata_out  <= ris_pkg::RD_ZERO;
        end else begin
            mode       <= next_mode;
            repeat_cfg <= next_repeat_cfg;
            irq_msk    <= next_irq_msk;
            irq_st     <= next_irq_st;
            rdata_out  <= next_rdata;
        end
    end

    // ==========================================================
    // Outputs
    assign frame_start_out = frame_start;
    assign index_out       = out_idx;
    assign mode_out        = mode;
    assign active_out      = active;
    assign irq_out         = |(irq_st & irq_msk);
endmodule // ris_sequencer
`default_nettype wire

// ==== core/ris_pkg.sv ====
// Package: register map, field layout and modes of the ROI index sequencer
`default_nettype none
package ris_pkg;
    localparam int unsigned NUM_INDEX  = 10;
    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned DATA_W     = 32;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_REPEAT  = 8'h04;
    localparam logic [7:0] OFS_CMD     = 8'h08;
    localparam logic [7:0] OFS_STATUS  = 8'h0C;
    localparam logic [7:0] OFS_IRQ_ST  = 8'h10;
    localparam logic [7:0] OFS_IRQ_MSK = 8'h14;
    localparam logic [7:0] OFS_TABLE   = 8'h20;
    // Control fields
    localparam int unsigned CTRL_MODE_LSB  = 0;
    localparam int unsigned CTRL_START_BIT = 4;
    localparam int unsigned CTRL_STOP_BIT  = 5;
    // Table entry fields: frames [7:0], successor [11:8], off flag bit 12
    localparam int unsigned ENT_FRM_LSB  = 0;
    localparam int unsigned ENT_SUCC_LSB = 8;
    localparam int unsigned ENT_OFF_BIT  = 12;
    // Status fields
    localparam int unsigned ST_IDX_LSB   = 0;
    localparam int unsigned ST_ACT_BIT   = 4;
    localparam int unsigned ST_FRM_LSB   = 8;
    localparam int unsigned ST_REP_LSB   = 16;
    // Interrupt bits
    localparam int unsigned IRQ_FRAME = 0;
    localparam int unsigned IRQ_PASS  = 1;
    localparam int unsigned IRQ_STOP  = 2;
    localparam int unsigned IRQ_IGN   = 3;
    localparam int unsigned IRQ_W     = 4;
    // Reset values
    localparam logic [7:0]  RST_FRAMES = 8'h01;
    localparam logic [7:0]  RST_REPEAT = 8'h01;
    localparam logic [3:0]  RST_INDEX  = 4'h0;
    localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        RIS_MODE_NORMAL,
        RIS_MODE_TRIG_SEQ,
        RIS_MODE_CMD_SEQ,
        RIS_MODE_MULTI
    } ris_mode_e;
endpackage
`default_nettype wire

// ==== core/ris_sync.sv ====
// Two-stage synchroniser with rising-edge pulse for the trigger pin
`default_nettype none
module ris_sync (
    input  wire logic ref_clk_in,
    input  wire logic rst_n_in,
    input  wire logic async_in,
    output logic      rise_out
);
    logic meta;
    logic sync;
    logic sync_d;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta   <= 1'b0;
            sync   <= 1'b0;
            sync_d <= 1'b0;
        end else begin
            meta   <= async_in;
            sync   <= meta;
            sync_d <= sync;
        end
    end

    assign rise_out = sync & ~sync_d;
endmodule // ris_sync
`default_nettype wire

// ==== sim/ris_seq_monitor.sv ====
// Port-level checker of the index sequencer
`default_nettype none
module ris_seq_monitor (
    input wire logic        ref_clk_in,
    input wire logic        rst_n_in,
    input wire logic [7:0]  addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic        trigger_in,
    input wire logic        frame_start_out,
    input wire logic [3:0]  index_out,
    input wire logic [1:0]  mode_out,
    input wire logic        active_out,
    input wire logic        irq_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    logic first_pend;
    logic next_first_pend;
    logic ctrl_wr;
    assign ctrl_wr = wr_in && addr_in == ris_pkg::OFS_CTRL;
    // First frame after start still pending
    always_comb begin
        next_first_pend = first_pend;
        if (frame_start_out || (wr_in && addr_in == ris_pkg::OFS_CMD)) next_first_pend = 1'b0;
        if (ctrl_wr && wdata_in[ris_pkg::CTRL_START_BIT]) next_first_pend = 1'b1;
    end
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) first_pend <= 1'b0;
        else first_pend <= next_first_pend;
    end
    sequence s_start_wr;
        ctrl_wr && wdata_in[ris_pkg::CTRL_START_BIT] && !wdata_in[ris_pkg::CTRL_STOP_BIT];
    endsequence
    sequence s_ctrl_wr;
        ctrl_wr;
    endsequence
    fs_single_a: assert property (frame_start_out |=> !frame_start_out)
        else $error("frame start longer than one cycle");
    fs_active_a: assert property (frame_start_out |-> $past(active_out))
        else $error("frame start while not active");
    rd_idle_a: assert property (!$past(rd_in) |-> rdata_out == ris_pkg::RD_ZERO)
        else $error("read data not zero outside read answer");
    idx_range_a: assert property (index_out < 4'hA)
        else $error("index beyond table");
    mode_hold_a: assert property (!ctrl_wr |=> $stable(mode_out))
        else $error("mode changed without control write");
    mode_write_a: assert property (s_ctrl_wr |=> mode_out == $past(wdata_in[1:0]))
        else $error("mode not taken from control write");
    start_act_a: assert property (s_start_wr |=> active_out)
        else $error("start did not activate");
    act_rise_a: assert property (!ctrl_wr |=> !$rose(active_out))
        else $error("active rose without start write");
    idx_change_a: assert property ($changed(index_out) |-> frame_start_out || $past(wr_in))
        else $error("index changed without frame or write");
    first_idx_a: assert property (frame_start_out && first_pend |-> index_out == 4'h0)
        else $error("first frame after start not index zero");
    act_fall_a: assert property ($fell(active_out) |->
        frame_start_out || $past(frame_start_out) || $past(frame_start_out, 2) || $past(wr_in))
        else $error("active fell without last frame or write");
    irq_fall_a: assert property ($fell(irq_out) |-> $past(wr_in))
        else $error("interrupt fell without write");
endmodule // ris_seq_monitor
`default_nettype wire

// ==== sim/ris_trig_src.sv ====
// External trigger source model
`default_nettype none
module ris_trig_src (
    input  wire logic ref_clk_in,
    input  wire logic rst_n_in,
    input  wire logic fire_in,
    output logic      trig_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cnt;
    logic [2:0] next_cnt;
    always_comb begin
        next_cnt = cnt;
        if (cnt != 3'h0) next_cnt = cnt - 3'h1;
        else if (fire_in) next_cnt = 3'h6;
    end
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) cnt <= 3'h0;
        else cnt <= next_cnt;
    end
    // One pulse of four cycles per frame
    assign trig_out = cnt > 3'h2;
endmodule // ris_trig_src
`default_nettype wire

// ==== sim/tb_top.sv ====
// Testbench of the index sequencer
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} ris_row_s;
    logic        ref_clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic [7:0]  addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0000_0000;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic        fire = 1'b0;
    logic        trigger_in;
    logic [31:0] rdata_out;
    logic        frame_start_out;
    logic        active_out;
    logic        irq_out;
    logic [3:0]  index_out;
    logic [1:0]  mode_out;
    logic [31:0] rv;
    int          fail_count = 0;
    int          n_tests = 0;
    logic [3:0]  exp_seq [6] = '{4'h0, 4'h0, 4'h1, 4'h0, 4'h0, 4'h1};
    ris_row_s    rows [7] = '{'{ris_pkg::OFS_REPEAT, 32'h3, 32'h3},
        '{ris_pkg::OFS_REPEAT, 32'h0, 32'h3}, '{ris_pkg::OFS_IRQ_MSK, 32'hF, 32'hF},
        '{ris_pkg::OFS_IRQ_MSK, 32'h0, 32'h0}, '{8'h48, 32'h55, 32'h0},
        '{8'h28, 32'h0000_1205, 32'h0000_1205}, '{ris_pkg::OFS_CTRL, 32'h3, 32'h3}};
    always #20 ref_clk_in = ~ref_clk_in;
    ris_sequencer #(.NUM_INDEX(10)) DUT (.ref_clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in,
        .rd_in, .rdata_out, .trigger_in, .frame_start_out, .index_out, .mode_out, .active_out,
        .irq_out);
    ris_trig_src u_trg (.ref_clk_in, .rst_n_in, .fire_in(fire), .trig_out(trigger_in));
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask
    // Fire one trigger, expect a frame or none
    task automatic trg(input string n, input logic hit, input logic [3:0] e);
        logic seen;
        seen = 1'b0;
        @(posedge ref_clk_in);
        fire <= 1'b1;
        @(posedge ref_clk_in);
        fire <= 1'b0;
        for (int i = 0; i < 14 && !seen; i++) begin
            @(posedge ref_clk_in);
            #1 seen = frame_start_out === 1'b1;
            if (seen) rv = {28'h0, index_out};
        end
        chk({n, " frame"}, {31'h0, hit}, {31'h0, seen});
        if (hit) chk({n, " index"}, {28'h0, e}, rv);
        repeat (6) @(posedge ref_clk_in);
    endtask
    initial begin
        #(40 * 5000);
        fail_count++;
        print_verdict();
    end
    initial begin
        repeat (3) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        #1 chk("reset outputs", 32'h0, {24'h0, index_out, mode_out, active_out, irq_out});
        rd(ris_pkg::OFS_REPEAT, rv);
        chk("repeat reset", 32'h1, rv);
        rd(ris_pkg::OFS_TABLE, rv);
        chk("entry reset", 32'h1, rv);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rv);
            chk("register row", rows[i].e, rv);
        end
        $display("test registers done");
        wr(ris_pkg::OFS_TABLE, 32'h0000_0102);
        wr(ris_pkg::OFS_TABLE + 8'h04, 32'h0000_1001);
        wr(ris_pkg::OFS_REPEAT, 32'h2);
        wr(ris_pkg::OFS_CTRL, 32'h11);
        foreach (exp_seq[i]) trg("trigger seq", 1'b1, exp_seq[i]);
        trg("after stop", 1'b0, 4'h0);
        chk("stopped", 32'h0, {31'h0, active_out});
        rd(ris_pkg::OFS_STATUS, rv);
        chk("status stopped", 32'h0, rv & 32'h00FF_0010);
        rd(ris_pkg::OFS_IRQ_ST, rv);
        chk("ignored flag", 32'h8, rv & 32'h8);
        wr(ris_pkg::OFS_IRQ_MSK, 32'h8);
        #1 chk("irq raised", 32'h1, {31'h0, irq_out});
        wr(ris_pkg::OFS_IRQ_ST, 32'hF);
        #1 chk("irq cleared", 32'h0, {31'h0, irq_out});
        $display("test trigger sequence done");
        wr(ris_pkg::OFS_CTRL, 32'h10);
        wr(ris_pkg::OFS_CMD, 32'h3);
        wr(ris_pkg::OFS_CTRL, 32'h2);
        #1 chk("mode", 32'h2, {30'h0, mode_out});
        trg("cmd none", 1'b1, 4'h0);
        wr(ris_pkg::OFS_CMD, 32'h7);
        trg("cmd 7", 1'b1, 4'h7);
        trg("cmd again", 1'b1, 4'h7);
        wr(ris_pkg::OFS_CMD, 32'hC);
        trg("cmd refused", 1'b1, 4'h7);
        rd(ris_pkg::OFS_CMD, rv);
        chk("cmd kept", 32'h7, rv);
        wr(ris_pkg::OFS_CMD, 32'h9);
        trg("cmd 9", 1'b1, 4'h9);
        wr(ris_pkg::OFS_CTRL, 32'h13);
        trg("multi", 1'b1, 4'h0);
        wr(ris_pkg::OFS_CTRL, 32'h2);
        wr(ris_pkg::OFS_CMD, 32'h5);
        trg("cmd 5", 1'b1, 4'h5);
        wr(ris_pkg::OFS_CTRL, 32'h12);
        trg("restart", 1'b1, 4'h0);
        $display("test command sequence done");
        print_verdict();
    end
endmodule // tb_top
bind ris_sequencer ris_seq_monitor u_mon (.ref_clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in,
    .rd_in, .rdata_out, .trigger_in, .frame_start_out, .index_out, .mode_out, .active_out,
    .irq_out);
`default_nettype wire
